// ### hdl/srpe_top.v
// Soft reset and output pin enable registers behind an AXI4-Lite slave
// Assumes one clock CORE_CLK; mode straps are asynchronous pins
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "srpe_defines.vh"
// Overview of operation
// - Bit 1 holds switching blocks in reset
// - Bit 0 holds phase-locked loop in reset
// - Bit 5 enables clock output five
// - Bit 4 enables clock output four
// - Clocks four, five need master or slave-pll
// - Bit 3 enables clock and pulse three
// - Bit 2 enables clock and pulse two
// - Bit 1 enables clock and pulse one
// - Bit 0 enables clock and pulse zero
module srpe_top (
	input wire CORE_CLK,
	input wire RST_B,
	input wire [5:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [5:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire MASTER_MODE_PIN,
	input wire SLAVE_PLL_ENABLE_PIN,
	output reg SWITCH_SOFT_RESET,
	output reg PLL_SOFT_RESET,
	output wire CLOCK_OUT_OE0,
	output wire CLOCK_OUT_OE1,
	output wire CLOCK_OUT_OE2,
	output wire CLOCK_OUT_OE3,
	output wire FRAME_PULSE_OUT_OE0,
	output wire FRAME_PULSE_OUT_OE1,
	output wire FRAME_PULSE_OUT_OE2,
	output wire FRAME_PULSE_OUT_OE3,
	output wire CLOCK_OUT4_OE,
	output wire CLOCK_OUT5_OE,
	output wire OFFSET_PULSE0_OE,
	output wire OFFSET_PULSE1_OE,
	output wire OFFSET_PULSE2_OE
);
	reg [15:0] soft_reset_control_ff;
	reg [15:0] output_clock_pulse_enables_ff;
	reg [15:0] mode_ff;
	reg [5:0] aw_addr_ff;
	reg aw_have_ff;
	reg [31:0] w_data_ff;
	reg [3:0] w_strb_ff;
	reg w_have_ff;
	reg [15:0] nxt_wval;
	reg [15:0] nxt_rval;
	reg nxt_rok;
	reg [15:0] wcur;
	reg [15:0] wmask;
	reg wok;
	wire master_sync;
	wire slave_pll_sync;
	wire big_clk_ok;
	wire [3:0] aw_idx;
	wire [3:0] ar_idx;
	wire do_write;

	assign aw_idx = aw_addr_ff[5:2];
	assign ar_idx = S_AXI_ARADDR[5:2];
	assign do_write = aw_have_ff & w_have_ff & ~S_AXI_BVALID;

	srpe_sync3 u_sync_master (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.din(MASTER_MODE_PIN),
		.dout(master_sync)
	);

	srpe_sync3 u_sync_slvpll (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.din(SLAVE_PLL_ENABLE_PIN),
		.dout(slave_pll_sync)
	);

	// Clock outputs four and five need master, or slave with pll enable
	assign big_clk_ok = (master_sync | mode_ff[`SRPE_BIT_MASTER]) |
		(slave_pll_sync | mode_ff[`SRPE_BIT_SLV_PLL]);

	// Write decode for the current captured address
	always @*
	begin
		wcur = 16'h0000;
		wmask = 16'h0000;
		wok = 1'b1;
		if (aw_idx == `SRPE_IDX_SOFT_RESET)
		begin
			wcur = soft_reset_control_ff;
			wmask = `SRPE_MASK_SOFT_RESET;
		end
		else if (aw_idx == `SRPE_IDX_PIN_ENABLE)
		begin
			wcur = output_clock_pulse_enables_ff;
			wmask = `SRPE_MASK_PIN_ENABLE;
		end
		else if (aw_idx == `SRPE_IDX_MODE)
		begin
			wcur = mode_ff;
			wmask = `SRPE_MASK_MODE;
		end
		else
			wok = 1'b0;
		// Upper bits are kept at zero even if software writes ones
		nxt_wval = wcur;
		if (w_strb_ff[0])
			nxt_wval[7:0] = w_data_ff[7:0];
		if (w_strb_ff[1])
			nxt_wval[15:8] = w_data_ff[15:8];
		nxt_wval = nxt_wval & wmask;
	end

	// Read decode
	always @*
	begin
		nxt_rval = 16'h0000;
		nxt_rok = 1'b1;
		if (ar_idx == `SRPE_IDX_SOFT_RESET)
			nxt_rval = soft_reset_control_ff;
		else if (ar_idx == `SRPE_IDX_PIN_ENABLE)
			nxt_rval = output_clock_pulse_enables_ff;
		else if (ar_idx == `SRPE_IDX_MODE)
			nxt_rval = mode_ff;
		else if (ar_idx == `SRPE_IDX_STATUS)
			nxt_rval = {13'h0000, big_clk_ok, slave_pll_sync, master_sync};
		else
			nxt_rok = 1'b0;
	end

	// Write channels, taken in either order
	always @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `SRPE_RESP_OKAY;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			aw_addr_ff <= 6'h00;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			soft_reset_control_ff <= `SRPE_RST_SOFT_RESET;
			output_clock_pulse_enables_ff <= `SRPE_RST_PIN_ENABLE;
			mode_ff <= `SRPE_RST_MODE;
		end
		else
		begin
			S_AXI_AWREADY <= ~aw_have_ff & ~S_AXI_AWREADY & ~S_AXI_BVALID &
				S_AXI_AWVALID;
			S_AXI_WREADY <= ~w_have_ff & ~S_AXI_WREADY & ~S_AXI_BVALID &
				S_AXI_WVALID;
			if (S_AXI_AWVALID & S_AXI_AWREADY)
			begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID & S_AXI_WREADY)
			begin
				w_have_ff <= 1'b1;
				w_data_ff <= S_AXI_WDATA;
				w_strb_ff <= S_AXI_WSTRB;
			end
			if (do_write)
			begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wok ? `SRPE_RESP_OKAY : `SRPE_RESP_SLVERR;
				// Reset bits stay as written until software clears them
				if (aw_idx == `SRPE_IDX_SOFT_RESET)
					soft_reset_control_ff <= nxt_wval;
				else if (aw_idx == `SRPE_IDX_PIN_ENABLE)
					output_clock_pulse_enables_ff <= nxt_wval;
				else if (aw_idx == `SRPE_IDX_MODE)
					mode_ff <= nxt_wval;
			end
			else if (S_AXI_BVALID & S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// Read channel
	always @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `SRPE_RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
			if (S_AXI_ARVALID & S_AXI_ARREADY)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= {16'h0000, nxt_rval};
				S_AXI_RRESP <= nxt_rok ? `SRPE_RESP_OKAY : `SRPE_RESP_SLVERR;
			end
			else if (S_AXI_RVALID & S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	// Soft reset levels to the switching and pll blocks
	always @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			SWITCH_SOFT_RESET <= 1'b0;
			PLL_SOFT_RESET <= 1'b0;
		end
		else
		begin
			SWITCH_SOFT_RESET <=
				soft_reset_control_ff[`SRPE_BIT_SW_RST];
			PLL_SOFT_RESET <=
				soft_reset_control_ff[`SRPE_BIT_PLL_RST];
		end
	end

	// Pad enables, each registered one cycle after the register bit
	srpe_pin_gate u_ck0 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CP0]),
		.qualify(1'b1),
		.oe(CLOCK_OUT_OE0)
	);

	srpe_pin_gate u_fp0 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CP0]),
		.qualify(1'b1),
		.oe(FRAME_PULSE_OUT_OE0)
	);

	srpe_pin_gate u_ck1 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CP1]),
		.qualify(1'b1),
		.oe(CLOCK_OUT_OE1)
	);

	srpe_pin_gate u_fp1 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CP1]),
		.qualify(1'b1),
		.oe(FRAME_PULSE_OUT_OE1)
	);

	srpe_pin_gate u_ck2 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CP2]),
		.qualify(1'b1),
		.oe(CLOCK_OUT_OE2)
	);

	srpe_pin_gate u_fp2 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CP2]),
		.qualify(1'b1),
		.oe(FRAME_PULSE_OUT_OE2)
	);

	srpe_pin_gate u_ck3 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CP3]),
		.qualify(1'b1),
		.oe(CLOCK_OUT_OE3)
	);

	srpe_pin_gate u_fp3 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CP3]),
		.qualify(1'b1),
		.oe(FRAME_PULSE_OUT_OE3)
	);

	srpe_pin_gate u_ck4 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CK4]),
		.qualify(big_clk_ok),
		.oe(CLOCK_OUT4_OE)
	);

	srpe_pin_gate u_ck5 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_CK5]),
		.qualify(big_clk_ok),
		.oe(CLOCK_OUT5_OE)
	);

	srpe_pin_gate u_of0 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_OF0]),
		.qualify(1'b1),
		.oe(OFFSET_PULSE0_OE)
	);

	srpe_pin_gate u_of1 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_OF1]),
		.qualify(1'b1),
		.oe(OFFSET_PULSE1_OE)
	);

	srpe_pin_gate u_of2 (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(output_clock_pulse_enables_ff[`SRPE_BIT_OF2]),
		.qualify(1'b1),
		.oe(OFFSET_PULSE2_OE)
	);
endmodule // srpe_top
`default_nettype wire

// ### hdl/srpe_defines.vh
// Offsets, field positions, reset values for the soft reset and pin enables
// Included only by the top-level design file of this block
`ifndef SRPE_DEFINES_VH
`define SRPE_DEFINES_VH
`define SRPE_IDX_SOFT_RESET 4'h2
`define SRPE_IDX_PIN_ENABLE 4'h3
`define SRPE_IDX_MODE 4'h4
`define SRPE_IDX_STATUS 4'h5
`define SRPE_RST_SOFT_RESET 16'h0000
`define SRPE_RST_PIN_ENABLE 16'h0000
`define SRPE_RST_MODE 16'h0000
`define SRPE_MASK_SOFT_RESET 16'h0003
`define SRPE_MASK_PIN_ENABLE 16'h01ff
`define SRPE_MASK_MODE 16'h0003
`define SRPE_BIT_PLL_RST 0
`define SRPE_BIT_SW_RST 1
`define SRPE_BIT_MASTER 0
`define SRPE_BIT_SLV_PLL 1
`define SRPE_BIT_CP0 0
`define SRPE_BIT_CP1 1
`define SRPE_BIT_CP2 2
`define SRPE_BIT_CP3 3
`define SRPE_BIT_CK4 4
`define SRPE_BIT_CK5 5
`define SRPE_BIT_OF0 6
`define SRPE_BIT_OF1 7
`define SRPE_BIT_OF2 8
`define SRPE_RESP_OKAY 2'b00
`define SRPE_RESP_SLVERR 2'b10
`endif

// ### hdl/srpe_sync3.v
// Three-stage synchroniser for one pin level
// Assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module srpe_sync3 (
	input wire clk,
	input wire rst_b,
	input wire din,
	output reg dout
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			dout <= 1'b0;
		end
		else
		begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				dout <= s3_ff;
		end
	end
endmodule // srpe_sync3
`default_nettype wire

// ### hdl/srpe_pin_gate.v
// One registered output enable for a tristate pad
// Assumes enable and qualifier are on clk
`timescale 1ns/1ps
`default_nettype none
module srpe_pin_gate (
	input wire clk,
	input wire rst_b,
	input wire enable,
	input wire qualify,
	output reg oe
);
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			oe <= 1'b0;
		else
			oe <= enable & qualify;
	end
endmodule // srpe_pin_gate
`default_nettype wire

// ### sim/srpe_top_props.sv
// Checker for the soft reset and pad enable block
// Assumes only the ports of srpe_top, one clock CORE_CLK
`timescale 1ns/1ps
`default_nettype none
module srpe_props (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic SWITCH_SOFT_RESET,
	input wire logic PLL_SOFT_RESET,
	input wire logic CLOCK_OUT_OE0,
	input wire logic CLOCK_OUT_OE1,
	input wire logic CLOCK_OUT_OE2,
	input wire logic CLOCK_OUT_OE3,
	input wire logic FRAME_PULSE_OUT_OE0,
	input wire logic FRAME_PULSE_OUT_OE1,
	input wire logic FRAME_PULSE_OUT_OE2,
	input wire logic FRAME_PULSE_OUT_OE3,
	input wire logic OFFSET_PULSE0_OE,
	input wire logic OFFSET_PULSE1_OE,
	input wire logic OFFSET_PULSE2_OE
);
default clocking @(posedge CORE_CLK); endclocking
default disable iff (!RST_B);
a_pair_low: assert property (
	{CLOCK_OUT_OE1, CLOCK_OUT_OE0} == {FRAME_PULSE_OUT_OE1, FRAME_PULSE_OUT_OE0})
	else $error("low clock and pulse enables differ");
a_pair_high: assert property (
	{CLOCK_OUT_OE3, CLOCK_OUT_OE2} == {FRAME_PULSE_OUT_OE3, FRAME_PULSE_OUT_OE2})
	else $error("high clock and pulse enables differ");
a_switch_cause: assert property (
	$changed(SWITCH_SOFT_RESET) |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
	else $error("switch reset moved without a write");
a_pll_cause: assert property (
	$changed(PLL_SOFT_RESET) |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
	else $error("pll reset moved without a write");
a_pad_cause: assert property (
	$changed({OFFSET_PULSE2_OE, OFFSET_PULSE1_OE, OFFSET_PULSE0_OE, CLOCK_OUT_OE0})
	|-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
	else $error("pad enable moved without a write");
a_bresp_hold: assert property (
	S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
	else $error("write response dropped early");
a_rdata_hold: assert property (
	S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
	else $error("read data dropped early");
a_read_answer: assert property (
	S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID ##0
	S_AXI_RDATA[31:16] == 16'h0)
	else $error("read answer late or upper half set");
endmodule // srpe_props
bind srpe_top srpe_props chk (.CORE_CLK, .RST_B, .S_AXI_ARVALID,
	.S_AXI_ARREADY,
	.S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_BRESP, .S_AXI_BVALID,
	.S_AXI_BREADY, .SWITCH_SOFT_RESET, .PLL_SOFT_RESET, .CLOCK_OUT_OE0,
	.CLOCK_OUT_OE1, .CLOCK_OUT_OE2, .CLOCK_OUT_OE3, .FRAME_PULSE_OUT_OE0,
	.FRAME_PULSE_OUT_OE1, .FRAME_PULSE_OUT_OE2, .FRAME_PULSE_OUT_OE3,
	.OFFSET_PULSE0_OE, .OFFSET_PULSE1_OE, .OFFSET_PULSE2_OE);
`default_nettype wire

// ### sim/srpe_top_bench.sv
// Self-checking bench for the soft reset and pad enable block
// Assumes srpe_top with its AXI4-Lite slave and mode pins
`timescale 1ns/1ps
`default_nettype none
module srpe_top_bench;
logic CORE_CLK = 0, RST_B = 0, MASTER_MODE_PIN = 0, SLAVE_PLL_ENABLE_PIN = 0;
logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
logic [5:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
logic [31:0] S_AXI_WDATA = 0;
logic [3:0] S_AXI_WSTRB = 0;
wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
wire [31:0] S_AXI_RDATA;
wire SWITCH_SOFT_RESET, PLL_SOFT_RESET, CLOCK_OUT4_OE, CLOCK_OUT5_OE;
wire CLOCK_OUT_OE0, CLOCK_OUT_OE1, CLOCK_OUT_OE2, CLOCK_OUT_OE3;
wire FRAME_PULSE_OUT_OE0, FRAME_PULSE_OUT_OE1, FRAME_PULSE_OUT_OE2;
wire FRAME_PULSE_OUT_OE3, OFFSET_PULSE0_OE, OFFSET_PULSE1_OE, OFFSET_PULSE2_OE;
int num_errors = 0;
int compares = 0;
// Strobe lanes for the next write, and edges before ready rises
logic [3:0] strb = 4'hf;
int lag = 0;
logic [31:0] lfsr = 32'h0001184a;
logic [5:0] bad [4] = '{6'h00, 6'h04, 6'h18, 6'h3c};
srpe_top dut (.CORE_CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
	.S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
	.S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
	.S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .MASTER_MODE_PIN,
	.SLAVE_PLL_ENABLE_PIN, .SWITCH_SOFT_RESET, .PLL_SOFT_RESET, .CLOCK_OUT_OE0,
	.CLOCK_OUT_OE1, .CLOCK_OUT_OE2, .CLOCK_OUT_OE3, .FRAME_PULSE_OUT_OE0,
	.FRAME_PULSE_OUT_OE1, .FRAME_PULSE_OUT_OE2, .FRAME_PULSE_OUT_OE3,
	.CLOCK_OUT4_OE, .CLOCK_OUT5_OE, .OFFSET_PULSE0_OE, .OFFSET_PULSE1_OE,
	.OFFSET_PULSE2_OE);
always #20 CORE_CLK = ~CORE_CLK;
function automatic logic [31:0] nxt(input logic [31:0] s);
	return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
// Clocks four and five may run: master or slave with pll enabled
function automatic logic allowed(input logic [31:0] v);
	return (v[20] & v[24]) | (v[21] & v[25]) | (|v[23:22]);
endfunction
task automatic complete_run;
	$display("num_errors %0d compares %0d", num_errors, compares);
	if (num_errors == 0 && compares > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	compares++;
	if (got !== exp)
	begin
		num_errors++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
// One clock edge, cut short when a wait runs too long
task automatic tick(inout int n);
	@(posedge CORE_CLK);
	n++;
	if (n > 64)
	begin
		num_errors++;
		complete_run();
	end
endtask
// One write; ready for the answer is held from lag edges on
task automatic wr(input logic [5:0] a, input logic [31:0] d,
	output logic [1:0] r);
	int n = 0;
	bit aw = 0;
	bit w = 0;
	bit b = 0;
	S_AXI_AWADDR <= a;
	S_AXI_WDATA <= d;
	S_AXI_WSTRB <= strb;
	S_AXI_AWVALID <= 1'h1;
	S_AXI_WVALID <= 1'h1;
	S_AXI_BREADY <= (lag == 0);
	while (!b)
	begin
		tick(n);
		aw |= S_AXI_AWREADY;
		w |= S_AXI_WREADY;
		b = S_AXI_BVALID && S_AXI_BREADY;
		r = S_AXI_BRESP;
		S_AXI_AWVALID <= !aw;
		S_AXI_WVALID <= !w;
		if (!b)
			S_AXI_BREADY <= (n >= lag);
	end
	S_AXI_BREADY <= 1'h0;
	tick(n);
endtask
// One read; data taken at the edge where valid and ready meet
task automatic rchk(input logic [5:0] a, input logic [31:0] e,
	input logic [1:0] er);
	int n = 0;
	bit got = 0;
	logic [31:0] d;
	logic [1:0] rr;
	S_AXI_ARADDR <= a;
	S_AXI_ARVALID <= 1'h1;
	S_AXI_RREADY <= (lag == 0);
	while (!got)
	begin
		tick(n);
		if (S_AXI_ARREADY)
			S_AXI_ARVALID <= 1'h0;
		got = S_AXI_RVALID && S_AXI_RREADY;
		d = S_AXI_RDATA;
		rr = S_AXI_RRESP;
		if (!got)
			S_AXI_RREADY <= (n >= lag);
	end
	S_AXI_RREADY <= 1'h0;
	chk(d, e);
	chk(rr, er);
	tick(n);
endtask
task automatic all_low;
	chk({SWITCH_SOFT_RESET, PLL_SOFT_RESET, CLOCK_OUT4_OE, CLOCK_OUT5_OE,
		CLOCK_OUT_OE0, CLOCK_OUT_OE1, CLOCK_OUT_OE2, CLOCK_OUT_OE3,
		FRAME_PULSE_OUT_OE0, FRAME_PULSE_OUT_OE1, FRAME_PULSE_OUT_OE2,
		FRAME_PULSE_OUT_OE3, OFFSET_PULSE0_OE, OFFSET_PULSE1_OE,
		OFFSET_PULSE2_OE}, 32'h0);
endtask
initial
begin
	logic [31:0] v;
	logic [1:0] r;
	repeat (8) @(posedge CORE_CLK);
	RST_B <= 1'h1;
	@(posedge CORE_CLK);
	all_low();
	rchk(6'h08, 32'h0, 2'h0);
	rchk(6'h0c, 32'h0, 2'h0);
	for (int i = 0; i < 24; i++)
	begin
		lfsr = nxt(lfsr);
		lag = i[0] ? 6 : 0;
		v = (i == 0) ? 32'h000001ff : lfsr;
		MASTER_MODE_PIN <= v[20] & v[24];
		SLAVE_PLL_ENABLE_PIN <= v[21] & v[25];
		wr(6'h10, {30'h0, v[23:22]}, r);
		chk(r, 2'h0);
		wr(6'h08, {30'h0, i[1:0]}, r);
		wr(6'h0c, v & 32'h1ff, r);
		chk(r, 2'h0);
		repeat (8) @(posedge CORE_CLK);
		rchk(6'h0c, v & 32'h1ff, 2'h0);
		rchk(6'h10, v[23:22], 2'h0);
		rchk(6'h14, {allowed(v), v[21] & v[25], v[20] & v[24]},
			2'h0);
		chk({SWITCH_SOFT_RESET, PLL_SOFT_RESET},
			i[1:0]);
		chk({OFFSET_PULSE2_OE, OFFSET_PULSE1_OE, OFFSET_PULSE0_OE},
			v[8:6]);
		chk(CLOCK_OUT5_OE, v[5] & allowed(v));
		chk(CLOCK_OUT4_OE, v[4] & allowed(v));
		chk({CLOCK_OUT_OE3, CLOCK_OUT_OE2, CLOCK_OUT_OE1, CLOCK_OUT_OE0},
			v[3:0]);
		chk({FRAME_PULSE_OUT_OE3, FRAME_PULSE_OUT_OE2, FRAME_PULSE_OUT_OE1,
			FRAME_PULSE_OUT_OE0}, v[3:0]);
	end
	foreach (bad[k])
	begin
		wr(bad[k], 32'h0000ffff, r);
		chk(r, 2'h2);
		rchk(bad[k], 32'h0, 2'h2);
	end
	wr(6'h14, 32'h0, r);
	chk(r, 2'h2);
	rchk(6'h0c, v & 32'h1ff, 2'h0);
	// Single lanes: the other byte keeps its old value
	strb = 4'h2;
	wr(6'h0c, 32'h00000100, r);
	rchk(6'h0c, 32'h100 | (v & 32'hff), 2'h0);
	strb = 4'h1;
	wr(6'h0c, 32'h0000005a, r);
	rchk(6'h0c, 32'h0000015a, 2'h0);
	chk(OFFSET_PULSE2_OE, 1'h1);
	chk(CLOCK_OUT_OE1, 1'h1);
	chk(CLOCK_OUT_OE0, 1'h0);
	strb = 4'hf;
	RST_B <= 1'h0;
	repeat (3) @(posedge CORE_CLK);
	all_low();
	RST_B <= 1'h1;
	@(posedge CORE_CLK);
	rchk(6'h08, 32'h0, 2'h0);
	rchk(6'h0c, 32'h0, 2'h0);
	complete_run();
end
endmodule // srpe_top_bench
`default_nettype wire
